// *** verilog/cscb_pkg.sv ***
// constants for the clock synthesizer control byte bank
package cscb_pkg;

    // ------------------------------------------------------------
    // command code and byte offsets
    // ------------------------------------------------------------
    localparam int       BYTE_ACCESS_BIT = 7;
    localparam logic [6:0] OFS_SW_FREQ   = 7'h00;
    localparam logic [6:0] OFS_MID       = 7'h01;
    localparam logic [6:0] OFS_PERIPH    = 7'h02;
    localparam logic [6:0] OFS_FREE_REF  = 7'h03;
    localparam logic [6:0] OFS_MULT      = 7'h04;
    localparam logic [6:0] OFS_STRAP     = 7'h05;
    localparam logic [6:0] OFS_IDENT     = 7'h06;
    localparam logic [6:0] OFS_SPARE     = 7'h07;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FREE_RUN_LO    = 5;
    localparam int DEBUG_CPU_BIT  = 3;
    localparam int MULT_OVR_BIT   = 7;
    localparam int SW_MULT_LO     = 5;
    localparam int STRAP_LO       = 3;
    localparam int FREQ_OVR_BIT   = 2;
    localparam int LOW_SPEED_BIT  = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MID_RST       = 3'h7;
    localparam logic [6:0] PERIPH_RST    = 7'h7f;
    localparam logic [2:0] FREE_RUN_RST  = 3'h7;
    localparam logic       DEBUG_CPU_RST = 1'h1;
    localparam logic [1:0] REF_OUT_RST   = 2'h3;
    localparam logic       MULT_OVR_RST  = 1'h0;
    localparam logic [1:0] SW_MULT_RST   = 2'h0;
    localparam logic       FREQ_OVR_RST  = 1'h0;
    localparam logic       LOW_SPEED_RST = 1'h0;
    localparam logic [4:0] SW_FREQ_RST   = 5'h00;

    // output high current as a multiple of the reference current
    typedef enum logic [1:0] {
        MULT_4X = 2'b00,
        MULT_5X = 2'b01,
        MULT_6X = 2'b10,
        MULT_7X = 2'b11
    } cscb_mult_e;

endpackage

// *** verilog/cscb_control_bytes.sv ***
// control and status byte bank of the clock synthesizer
// How it works
// R1 - byte 1 bits 2..0 enable mid clocks, one runs, reset one
// R2 - byte 2 bits 6..0 enable peripheral clocks, reset one; bit 7 reads zero
// R3 - byte 3 enables free-run, debug cpu, reference outputs; bits 4,2 zero
// R4 - byte 4 bit 7 picks pins or software bits for multiplier
// R5 - software multiplier codes 00..11 mean 4x..7x reference current
// R6 - byte 5 bits 7..3 return latched strap levels, read only
// R7 - byte 5 bit 2 picks strap or software frequency select
// R8 - byte 5 bit 0 picks 24 or 48 MHz low-speed output
// R9 - byte 6 bits 7..4 give a fixed revision code
// R10 - byte 6 bits 3..0 give a fixed maker code, writes ignored
// R11 - command msb one means byte access; low seven bits are offset
// R12 - software frequency select sits in byte 0 bits 4..0, reset zero
// R13 - straps captured once after reset release, then held
// R14 - reserved bits ignore writes and read zero
`timescale 1ns/1ps
module cscb_control_bytes
    import cscb_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
    parameter logic [3:0] MAKER_CODE    = 4'h5  // arbitrary value
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [7:0] cmdCode,
    input  wire logic       wrStrobe,
    input  wire logic [7:0] wrData,
    input  wire logic       rdStrobe,
    output logic      [7:0] rdData,
    output logic            rdValid,
    input  wire logic [4:0] freqStrapInputs,
    input  wire logic [1:0] multiplierSelectPins,
    output logic      [2:0] midClkEnable,
    output logic      [6:0] periphClkEnable,
    output logic      [2:0] freeRunPeriphClkEnable,
    output logic            debugCpuClkEnable,
    output logic      [1:0] referenceOutEnable,
    output logic      [1:0] multiplierCode,
    output logic      [2:0] iohMultiple,
    output logic      [4:0] freqSelect,
    output logic            lowSpeedOutFreqSelect
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic       byteAccess;
    logic [6:0] offset;
    logic       wrHit;
    logic [7:0] readMux;

    logic       multiplierSwOverride_reg;
    logic [1:0] swMultiplierSel_reg;
    logic       freqSourceOverride_reg;
    logic [4:0] swFreqSel_reg;
    logic [4:0] freqStrapLatched_reg;
    logic       strapCaptured_reg;

    assign byteAccess = cmdCode[BYTE_ACCESS_BIT];        // see R11
    assign offset     = cmdCode[6:0];                    // see R11
    assign wrHit      = wrStrobe && byteAccess;

    // ------------------------------------------------------------
    // writable bytes
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            swFreqSel_reg <= SW_FREQ_RST;
        end else if (wrHit && offset == OFS_SW_FREQ) begin
            swFreqSel_reg <= wrData[4:0];                // see R12
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            midClkEnable <= MID_RST;
        end else if (wrHit && offset == OFS_MID) begin
            midClkEnable <= wrData[2:0];                 // see R1
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            periphClkEnable <= PERIPH_RST;
        end else if (wrHit && offset == OFS_PERIPH) begin
            periphClkEnable <= wrData[6:0];              // see R2
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            freeRunPeriphClkEnable <= FREE_RUN_RST;
            debugCpuClkEnable      <= DEBUG_CPU_RST;
            referenceOutEnable     <= REF_OUT_RST;
        end else if (wrHit && offset == OFS_FREE_REF) begin
            freeRunPeriphClkEnable <= wrData[FREE_RUN_LO +: 3]; // see R3
            debugCpuClkEnable      <= wrData[DEBUG_CPU_BIT];    // see R3
            referenceOutEnable     <= wrData[1:0];              // see R3
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            multiplierSwOverride_reg <= MULT_OVR_RST;
            swMultiplierSel_reg      <= SW_MULT_RST;
        end else if (wrHit && offset == OFS_MULT) begin
            multiplierSwOverride_reg <= wrData[MULT_OVR_BIT];       // see R4
            swMultiplierSel_reg      <= wrData[SW_MULT_LO +: 2];    // see R5
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            freqSourceOverride_reg <= FREQ_OVR_RST;
            lowSpeedOutFreqSelect  <= LOW_SPEED_RST;
        end else if (wrHit && offset == OFS_STRAP) begin
            freqSourceOverride_reg <= wrData[FREQ_OVR_BIT];  // see R7
            lowSpeedOutFreqSelect  <= wrData[LOW_SPEED_BIT]; // see R8
        end
    end

    // ------------------------------------------------------------
    // strap latch
    // ------------------------------------------------------------
    // the strap pins turn into clock outputs later, so take them only once
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strapCaptured_reg    <= 1'b0;
            freqStrapLatched_reg <= 5'h00;
        end else if (!strapCaptured_reg) begin
            strapCaptured_reg    <= 1'b1;                // see R13
            freqStrapLatched_reg <= freqStrapInputs;     // see R13
        end
    end

    // ------------------------------------------------------------
    // effective selections
    // ------------------------------------------------------------
    // one cycle behind the control bits so every output leaves a flop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            multiplierCode <= MULT_4X;
            iohMultiple    <= 3'h4;
        end else begin
            if (multiplierSwOverride_reg) begin          // see R4
                multiplierCode <= swMultiplierSel_reg;
                iohMultiple    <= {1'b1, swMultiplierSel_reg};  // see R5
            end else begin
                multiplierCode <= multiplierSelectPins;
                iohMultiple    <= {1'b1, multiplierSelectPins}; // see R5
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            freqSelect <= 5'h00;
        end else if (freqSourceOverride_reg) begin       // see R7
            freqSelect <= swFreqSel_reg;
        end else begin
            freqSelect <= freqStrapLatched_reg;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        readMux = 8'h00;                                 // see R14
        case (offset)
            OFS_SW_FREQ:  readMux = {3'h0, swFreqSel_reg};
            OFS_MID:      readMux = {5'h00, midClkEnable};
            OFS_PERIPH:   readMux = {1'b0, periphClkEnable};        // see R2
            OFS_FREE_REF: readMux = {freeRunPeriphClkEnable, 1'b0,
                                     debugCpuClkEnable, 1'b0,
                                     referenceOutEnable};           // see R3
            OFS_MULT:     readMux = {multiplierSwOverride_reg,
                                     swMultiplierSel_reg, 5'h00};   // see R14
            OFS_STRAP:    readMux = {freqStrapLatched_reg,
                                     freqSourceOverride_reg, 1'b0,
                                     lowSpeedOutFreqSelect};        // see R6
            OFS_IDENT:    readMux = {REVISION_CODE, MAKER_CODE};    // see R9 R10
            default:      readMux = 8'h00;
        endcase
    end

    // non-byte commands still answer, with zero, so the engine never hangs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStrobe;
            if (rdStrobe) begin
                rdData <= byteAccess ? readMux : 8'h00;  // see R11
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_mid_write;
        wrStrobe && cmdCode == {1'b1, OFS_MID} |=> midClkEnable == $past(wrData[2:0]);
    endproperty
    a_mid_write: assert property (p_mid_write) else $error("mid enable not written"); // see R1

    property p_periph_read;
        wrStrobe && cmdCode == {1'b1, OFS_PERIPH} ##1 rdStrobe && cmdCode == {1'b1, OFS_PERIPH}
            |=> rdValid && rdData == {1'b0, $past(wrData[6:0], 2)};
    endproperty
    a_periph_read: assert property (p_periph_read) else $error("periph readback wrong"); // see R2

    property p_debug_write;
        wrStrobe && cmdCode == {1'b1, OFS_FREE_REF}
            |=> debugCpuClkEnable == $past(wrData[3]) && referenceOutEnable == $past(wrData[1:0]);
    endproperty
    a_debug_write: assert property (p_debug_write) else $error("byte 3 not written"); // see R3

    // gated on the sampled reset so the reset-time flop value is never compared
    property p_mult_source;
        reset_n |=> multiplierCode == ($past(multiplierSwOverride_reg) ?
                 $past(swMultiplierSel_reg) : $past(multiplierSelectPins));
    endproperty
    a_mult_source: assert property (p_mult_source) else $error("multiplier source wrong"); // see R4

    property p_ioh_scale;
        iohMultiple == 3'(multiplierCode + 3'h4);
    endproperty
    a_ioh_scale: assert property (p_ioh_scale) else $error("current multiple wrong"); // see R5

    property p_strap_held;
        strapCaptured_reg |=> $stable(freqStrapLatched_reg) && strapCaptured_reg;
    endproperty
    a_strap_held: assert property (p_strap_held) else $error("strap latch moved"); // see R13

    property p_freq_source;
        reset_n |=> freqSelect == ($past(freqSourceOverride_reg) ?
                 $past(swFreqSel_reg) : $past(freqStrapLatched_reg));
    endproperty
    a_freq_source: assert property (p_freq_source) else $error("frequency source wrong"); // see R7

    property p_ident_read;
        rdStrobe && cmdCode == {1'b1, OFS_IDENT} |=> rdData == {REVISION_CODE, MAKER_CODE};
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("identity byte wrong"); // see R10

    property p_spare_zero;
        rdStrobe && cmdCode == {1'b1, OFS_SPARE} |=> rdValid && rdData == 8'h00;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare byte not zero"); // see R14

    property p_no_byte_write;
        wrStrobe && !cmdCode[7] |=> $stable(periphClkEnable) && $stable(midClkEnable);
    endproperty
    a_no_byte_write: assert property (p_no_byte_write) else $error("non-byte write took"); // see R11

    c_sw_freq: cover property (freqSourceOverride_reg ##1 freqSelect == swFreqSel_reg);
    c_sw_mult: cover property (multiplierSwOverride_reg && swMultiplierSel_reg == MULT_7X);
    c_read_strap: cover property (rdStrobe && cmdCode == {1'b1, OFS_STRAP} ##1 rdValid);
    c_48mhz: cover property (lowSpeedOutFreqSelect);

endmodule // cscb_control_bytes

// *** tb/cscb_host_model.sv ***
// host-side model that issues byte commands to the control bytes
`timescale 1ns/1ps
module cscb_host_model (
    input  wire logic       mclk,
    output logic      [7:0] cmdCode,
    output logic            wrStrobe,
    output logic      [7:0] wrData,
    output logic            rdStrobe,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid
);
    initial begin
        cmdCode  = 8'h00;
        wrStrobe = 1'b0;
        wrData   = 8'h00;
        rdStrobe = 1'b0;
    end

    // ------------------------------------------------------------
    // one byte command; gap idles first to act as a slow host
    // ------------------------------------------------------------
    task automatic put(input logic [7:0] cmd, input logic [7:0] d, input logic wr,
                       input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        cmdCode  <= cmd;
        wrData   <= d;
        wrStrobe <= wr;
        rdStrobe <= !wr;
        @(posedge mclk);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        // released lines carry junk so stale values cannot pass
        cmdCode  <= ~cmd;
        wrData   <= ~d;
    endtask

    // ------------------------------------------------------------
    // write then read of the same byte on back-to-back edges
    // ------------------------------------------------------------
    task automatic putWrRd(input logic [7:0] cmd, input logic [7:0] d);
        @(posedge mclk);
        cmdCode  <= cmd;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge mclk);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        cmdCode  <= ~cmd;
        wrData   <= ~d;
    endtask
endmodule // cscb_host_model

// *** tb/tb_top.sv ***
// self-checking bench for the control byte bank
`timescale 1ns/1ps
module tb_top;
    import cscb_pkg::*;
    localparam logic [4:0] STRAP = 5'h16;
    logic       mclk          = 1'b0;
    logic       reset_n       = 1'b0;
    logic [4:0] freqStrap     = STRAP;
    logic [1:0] multPins      = 2'b10;
    logic [7:0] cmdCode, wrData, rdData;
    logic       wrStrobe, rdStrobe, rdValid, dbgEn, lowSpeed;
    logic [2:0] midEn, freeEn, ioh;
    logic [6:0] perEn;
    logic [1:0] refEn, multCode;
    logic [4:0] freqSel;
    int         errCount      = 0;
    int         checkCount    = 0;
    logic [7:0] rstExp[8]     = '{8'h00, 8'h07, 8'h7f, 8'heb, 8'h00, 8'hb0, 8'ha6, 8'h00};
    logic [7:0] mask[8]       = '{8'h1f, 8'h07, 8'h7f, 8'heb, 8'he0, 8'h05, 8'h00, 8'h00};
    logic [7:0] fix[8]        = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hb0, 8'ha6, 8'h00};
    logic [7:0] pat[4]        = '{8'hff, 8'ha5, 8'h5a, 8'h00};

    always #5 mclk = ~mclk;

    cscb_host_model host (.mclk(mclk), .cmdCode(cmdCode), .wrStrobe(wrStrobe),
        .wrData(wrData), .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid));

    // id values are arbitrary
    cscb_control_bytes #(.REVISION_CODE(4'ha), .MAKER_CODE(4'h6)) dut (
        .mclk(mclk), .reset_n(reset_n), .cmdCode(cmdCode), .wrStrobe(wrStrobe),
        .wrData(wrData), .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid),
        .freqStrapInputs(freqStrap), .multiplierSelectPins(multPins),
        .midClkEnable(midEn), .periphClkEnable(perEn), .freeRunPeriphClkEnable(freeEn),
        .debugCpuClkEnable(dbgEn), .referenceOutEnable(refEn), .multiplierCode(multCode),
        .iohMultiple(ioh), .freqSelect(freqSel), .lowSpeedOutFreqSelect(lowSpeed));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        host.put(cmd, d, 1'b1, 1);
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        host.put(cmd, 8'h00, 1'b0, 0);
        #1;
        check({7'h00, rdValid}, 8'h01);
        check(rdData, exp);
    endtask

    // effective selects lag their source by one more cycle
    task automatic tick;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic outs(input logic [7:0] d, input logic ls, input logic [1:0] m,
                        input logic [4:0] f);
        check({5'h00, midEn}, {5'h00, d[2:0]});
        check({1'b0, perEn}, {1'b0, d[6:0]});
        check({freeEn, 1'b0, dbgEn, 1'b0, refEn}, d & 8'heb);
        check({6'h00, multCode}, {6'h00, m});
        check({5'h00, ioh}, 8'h04 + {6'h00, m});
        check({3'h0, freqSel}, {3'h0, f});
        check({7'h00, lowSpeed}, {7'h00, ls});
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        freqStrap <= 5'h09;
        tick;
        outs(8'hff, 1'b0, 2'b10, STRAP);
        for (int i = 0; i < 8; i++) rd({1'b1, i[6:0]}, rstExp[i]);
        $display("reset values done");
        foreach (pat[k]) begin
            for (int i = 0; i < 8; i++) wr({1'b1, i[6:0]}, pat[k]);
            for (int i = 0; i < 8; i++) rd({1'b1, i[6:0]}, (pat[k] & mask[i]) | fix[i]);
            tick;
            outs(pat[k], pat[k][0], pat[k][7] ? pat[k][6:5] : 2'b10,
                 pat[k][2] ? pat[k][4:0] : STRAP);
        end
        $display("write and read back done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h84, {1'b1, c[1:0], 5'h1f});
            tick;
            check({5'h00, ioh}, 8'h04 + c[7:0]);
        end
        wr(8'h84, 8'h00);
        multPins <= 2'b01;
        tick;
        check({6'h00, multCode}, 8'h01);
        $display("multiplier codes done");
        host.putWrRd(8'h82, 8'h35);
        #1;
        check({7'h00, rdValid}, 8'h01);
        check(rdData, 8'h35);
        check({1'b0, perEn}, 8'h35);
        $display("back to back write and read done");
        wr(8'h01, 8'hff);
        rd(8'h81, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h88, 8'h00);
        wr(8'h86, 8'h00);
        rd(8'h86, 8'ha6);
        $display("refused accesses done");
        results;
    end

    initial begin
        #50000;
        errCount++;
        results;
    end
endmodule // tb_top
